// [shared/srsp_cfg.svh]
// Purpose: Named constants for the two-wire register slave port.
// Assumes: Included by bare name from design files.
// Notes: Definitions only.
`ifndef SRSP_CFG_SVH
`define SRSP_CFG_SVH

// Seven-bit slave address of the control-register port.
`define SRSP_OWN_ADDR 7'h5c
// Upper four address bits that belong to the on-chip EEPROM slave.
`define SRSP_EEPROM_PREFIX 4'ha
// Seven-bit general call address, never claimed.
`define SRSP_GENERAL_CALL 7'h00
// Number of control registers and pointer width.
`define SRSP_REG_COUNT 16
`define SRSP_PTR_W 4
// Bits in one byte, as seen by the bit counter.
`define SRSP_BYTE_BITS 4'h8
// Reset value of every control register.
`define SRSP_REG_RESET 8'h00
// Depth and width of the write buffer: pointer plus data byte.
`define SRSP_FIFO_DEPTH 8
`define SRSP_FIFO_WIDTH 12

`endif

// [shared/srsp_pkg.sv]
// Purpose: Types shared by the register slave port.
// Assumes: Nothing beyond the constant header.
// Notes: No constants live here; see srsp_cfg.svh.
package srsp_pkg;

   // Protocol phases of the slave.
   typedef enum logic [3:0] {
      SRSP_IDLE,
      SRSP_ADDR,
      SRSP_ADDR_ACK,
      SRSP_PTR,
      SRSP_PTR_ACK,
      SRSP_WR_DATA,
      SRSP_WR_ACK,
      SRSP_RD_DATA,
      SRSP_RD_ACK,
      SRSP_SKIP
   } srsp_state_t;

endpackage

// [rtl/srsp_fifo.sv]
// Purpose: Small valid/ready FIFO between the serial side and the registers.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Full and empty are exact; the drain side may stall freely.
`timescale 1ns/1ps
`default_nettype none

module srsp_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Filling side.
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side.
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrIdx;
   logic [AW-1:0] rdIdx;
   logic [AW:0] count;
   wire doPush;
   wire doPop;

   // Handshakes and occupancy flags.
   assign inReady = (count != FULL_COUNT);
   assign outValid = (count != '0);
   assign doPush = inValid && inReady;
   assign doPop = outValid && outReady;
   assign outData = mem[rdIdx];

   // Storage is written only on an accepted push.
   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrIdx] <= inData;
      end
   end

   // Indices wrap at the depth, which need not be a power of two.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrIdx <= '0;
         rdIdx <= '0;
         count <= '0;
      end else begin
         if (doPush) begin
            wrIdx <= (wrIdx == LAST_SLOT) ? '0 : AW'(wrIdx + 1'b1);
         end
         if (doPop) begin
            rdIdx <= (rdIdx == LAST_SLOT) ? '0 : AW'(rdIdx + 1'b1);
         end
         if (doPush && !doPop) begin
            count <= (AW+1)'(count + 1'b1);
         end else if (doPop && !doPush) begin
            count <= (AW+1)'(count - 1'b1);
         end
      end
   end

   // The count never passes the depth.
   a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
      count <= FULL_COUNT) else $error("FIFO count exceeds depth");

endmodule
`default_nettype wire

// [rtl/srsp_slave.sv]
// Purpose: Two-wire serial slave giving a bus master access to sixteen byte registers.
// Assumes: Serial pins and mode pin are asynchronous; clk is much faster than the link.
// Notes: Written bytes pass a FIFO before they reach the register file.
`timescale 1ns/1ps
`default_nettype none
`include "srsp_cfg.svh"

// Contract
// R01 - Slave only, never answers general call.
// R02 - Data falling with clock high: START.
// R03 - Data rising with clock high: STOP.
// R04 - Data changes only while clock low.
// R05 - One data bit per clock pulse.
// R06 - Master starts only on idle bus.
// R07 - Address then direction bit; own address 1011100.
// R08 - Never claim EEPROM addresses 1010xxx.
// R09 - Acknowledge received bytes low on ninth pulse. A data byte that finds the write buffer full is not acknowledged.
// R10 - Master gives a ninth clock per byte.
// R11 - On read NACK, release data line.
// R12 - Write: address, pointer, data, acknowledges, STOP.
// R13 - Aborted write leaves register unchanged.
// R14 - Pointer loaded before repeated START ends write.
// R15 - Read: readdress, acknowledge, send byte, NACK.
// R16 - Pointer increments after each written byte.
// R17 - Pointer wraps after sixteen registers.
// R18 - Byte committed when its acknowledge is driven.
// R19 - Pointer increments by one per read byte.
// R20 - Sequential read wraps through all registers.
// R21 - Port works only while mode low.
// R22 - All registers clear at power-up.
// R23 - Unmatched address: no acknowledge, ignore transfer.
// R24 - Bytes MSB first, sampled on clock high.
module srsp_slave #(
   parameter int FIFO_DEPTH = `SRSP_FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Mode select pin: low selects programming.
   input wire logic modePin,
   // Shared serial clock / power-down pin.
   input wire logic powerdown_or_serial_clock_pin,
   // Shared serial data / output-enable pin, open drain.
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Register update hold from the clock generator core.
   input wire logic regUpdateHold,
   // Control register contents, register 0 in the low byte.
   output logic [8*`SRSP_REG_COUNT-1:0] ctrlRegs,
   // Run-mode controls taken from the shared pins.
   output logic powerDownReq,
   output logic outputEnable
);

   localparam int PW = `SRSP_PTR_W;
   localparam int FW = `SRSP_FIFO_WIDTH;

   srsp_pkg::srsp_state_t state;
   logic [1:0] sclSync;
   logic [1:0] sdaSync;
   logic [1:0] modeSync;
   logic sclPrev;
   logic sdaPrev;
   logic [3:0] bitCnt;
   logic [7:0] rxShift;
   logic [7:0] txShift;
   logic [PW-1:0] ptr;
   logic rwRead;
   logic masterAck;
   logic [7:0] regFile [`SRSP_REG_COUNT];
   wire sclS;
   wire sdaS;
   wire modeS;
   wire sclRise;
   wire sclFall;
   wire startDet;
   wire stopDet;
   wire byteIn;
   wire dataPhase;
   wire addrHit;
   wire fifoInValid;
   wire fifoInReady;
   wire [FW-1:0] fifoInData;
   wire fifoOutValid;
   wire fifoOutReady;
   wire [FW-1:0] fifoOutData;
   wire [7:0] regAtPtr;

   // True when the address byte names this port and nothing else.
   function automatic logic isOwnAddr(input logic [6:0] addr);
      isOwnAddr = (addr == `SRSP_OWN_ADDR);
   endfunction

   // Two-stage synchronisers; only the second stage is read by logic.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         modeSync <= 2'h3;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclSync <= {sclSync[0], powerdown_or_serial_clock_pin};
         sdaSync <= {sdaSync[0], sdaIn};
         modeSync <= {modeSync[0], modePin};
         sclPrev <= sclSync[1];
         sdaPrev <= sdaSync[1];
      end
   end

   // Edge and bus-condition decoding on the synchronised lines.
   assign sclS = sclSync[1];
   assign sdaS = sdaSync[1];
   assign modeS = modeSync[1];
   assign sclRise = sclS && !sclPrev;
   assign sclFall = !sclS && sclPrev;
   assign startDet = sclS && sclPrev && sdaPrev && !sdaS; // R02
   assign stopDet = sclS && sclPrev && !sdaPrev && sdaS; // R03
   assign byteIn = (bitCnt == `SRSP_BYTE_BITS);
   assign dataPhase = (state == srsp_pkg::SRSP_ADDR) || (state == srsp_pkg::SRSP_PTR) ||
                      (state == srsp_pkg::SRSP_WR_DATA) || (state == srsp_pkg::SRSP_RD_DATA);
   assign addrHit = isOwnAddr(rxShift[7:1]); // R01 R07 R08 R23
   assign regAtPtr = regFile[ptr];

   // A complete data byte is queued on the fall that starts its acknowledge.
   assign fifoInValid = !modeS && !startDet && !stopDet && sclFall && byteIn &&
                        (state == srsp_pkg::SRSP_WR_DATA); // R13 R18
   assign fifoInData = {ptr, rxShift};
   assign fifoOutReady = !regUpdateHold;

   // The data line is only ever pulled low.
   assign sdaOut = 1'b0;

   // Protocol engine: bits sampled on clock rise, line changed on clock fall.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= srsp_pkg::SRSP_IDLE;
         bitCnt <= 4'h0;
         rxShift <= 8'h00;
         txShift <= 8'h00;
         sdaOe <= 1'b0;
         ptr <= '0;
         rwRead <= 1'b0;
         masterAck <= 1'b0;
      end else if (modeS) begin
         state <= srsp_pkg::SRSP_IDLE; // R21
         sdaOe <= 1'b0;
         bitCnt <= 4'h0;
      end else if (startDet) begin
         state <= srsp_pkg::SRSP_ADDR; // R02 R14
         sdaOe <= 1'b0;
         bitCnt <= 4'h0;
      end else if (stopDet) begin
         state <= srsp_pkg::SRSP_IDLE; // R03 R13
         sdaOe <= 1'b0;
         bitCnt <= 4'h0;
      end else if (sclRise) begin
         rxShift <= {rxShift[6:0], sdaS}; // R05 R24
         masterAck <= !sdaS;
         if (dataPhase) begin
            bitCnt <= 4'(bitCnt + 4'h1);
         end
      end else if (sclFall) begin
         case (state)
            srsp_pkg::SRSP_ADDR: begin
               if (byteIn) begin
                  bitCnt <= 4'h0;
                  if (addrHit) begin
                     sdaOe <= 1'b1; // R09
                     rwRead <= rxShift[0];
                     state <= srsp_pkg::SRSP_ADDR_ACK;
                  end else begin
                     state <= srsp_pkg::SRSP_SKIP; // R23
                  end
               end
            end
            srsp_pkg::SRSP_ADDR_ACK: begin
               if (rwRead) begin
                  txShift <= regAtPtr; // R15 R24
                  sdaOe <= !regAtPtr[7];
                  state <= srsp_pkg::SRSP_RD_DATA;
               end else begin
                  sdaOe <= 1'b0;
                  state <= srsp_pkg::SRSP_PTR;
               end
            end
            srsp_pkg::SRSP_PTR: begin
               if (byteIn) begin
                  bitCnt <= 4'h0;
                  ptr <= rxShift[PW-1:0]; // R12 R14
                  sdaOe <= 1'b1;
                  state <= srsp_pkg::SRSP_PTR_ACK;
               end
            end
            srsp_pkg::SRSP_PTR_ACK: begin
               sdaOe <= 1'b0;
               state <= srsp_pkg::SRSP_WR_DATA;
            end
            srsp_pkg::SRSP_WR_DATA: begin
               if (byteIn) begin
                  bitCnt <= 4'h0;
                  if (fifoInReady) begin
                     sdaOe <= 1'b1; // R09 R18
                     ptr <= PW'(ptr + 1'b1); // R16 R17
                     state <= srsp_pkg::SRSP_WR_ACK;
                  end else begin
                     state <= srsp_pkg::SRSP_SKIP;
                  end
               end
            end
            srsp_pkg::SRSP_WR_ACK: begin
               sdaOe <= 1'b0;
               state <= srsp_pkg::SRSP_WR_DATA;
            end
            srsp_pkg::SRSP_RD_DATA: begin
               if (byteIn) begin
                  bitCnt <= 4'h0;
                  sdaOe <= 1'b0;
                  ptr <= PW'(ptr + 1'b1); // R19 R20
                  state <= srsp_pkg::SRSP_RD_ACK;
               end else begin
                  sdaOe <= !txShift[6]; // R04 R24
                  txShift <= {txShift[6:0], 1'b0};
               end
            end
            srsp_pkg::SRSP_RD_ACK: begin
               if (masterAck) begin
                  txShift <= regAtPtr; // R20
                  sdaOe <= !regAtPtr[7];
                  state <= srsp_pkg::SRSP_RD_DATA;
               end else begin
                  sdaOe <= 1'b0; // R11
                  state <= srsp_pkg::SRSP_SKIP;
               end
            end
            default: begin
               sdaOe <= 1'b0;
            end
         endcase
      end
   end

   // Write buffer between the serial side and the register file.
   srsp_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) writeBuf (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // Register file, cleared at reset and loaded from the buffer.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `SRSP_REG_COUNT; i++) begin
            regFile[i] <= `SRSP_REG_RESET; // R22
         end
      end else if (fifoOutValid && fifoOutReady) begin
         regFile[fifoOutData[FW-1:8]] <= fifoOutData[7:0];
      end
   end

   // Flat view of the register file for the clock generator.
   generate
      for (genvar g = 0; g < `SRSP_REG_COUNT; g++) begin : gRegOut
         assign ctrlRegs[8*g +: 8] = regFile[g];
      end
   endgenerate

   // Run-mode meaning of the shared pins.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         powerDownReq <= 1'b0;
         outputEnable <= 1'b1;
      end else begin
         powerDownReq <= modeS && sclS; // R21
         outputEnable <= !modeS || sdaS;
      end
   end

   // Byte-completion events used by the checks below.
   sequence seqAddrDone;
      (state == srsp_pkg::SRSP_ADDR) && sclFall && byteIn && !startDet && !stopDet;
   endsequence

   sequence seqReadNack;
      (state == srsp_pkg::SRSP_RD_ACK) && sclFall && !masterAck && !startDet && !stopDet;
   endsequence

   a_own_addr_ack: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R07
      seqAddrDone and (rxShift[7:1] == `SRSP_OWN_ADDR) |=> sdaOe && state == srsp_pkg::SRSP_ADDR_ACK)
      else $error("Own address not acknowledged");
   a_eeprom_ignore: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R08
      seqAddrDone and (rxShift[7:4] == `SRSP_EEPROM_PREFIX) |=> !sdaOe[*3])
      else $error("EEPROM address claimed");
   a_general_call: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R01
      seqAddrDone and (rxShift[7:1] == `SRSP_GENERAL_CALL) |=> state == srsp_pkg::SRSP_SKIP)
      else $error("General call answered");
   a_mode_idle: assert property (@(posedge clk) disable iff (!rst_n) // R21
      modeS |=> state == srsp_pkg::SRSP_IDLE && !sdaOe) else $error("Port active in run mode");
   a_start_addr: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R02
      startDet |=> state == srsp_pkg::SRSP_ADDR && bitCnt == 4'h0) else $error("START missed");
   a_stop_abort: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R13
      stopDet |-> !fifoInValid ##1 (state == srsp_pkg::SRSP_IDLE && $stable(ptr)))
      else $error("STOP not honoured");
   a_commit_ack: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R18
      fifoInValid && fifoInReady |=> sdaOe && state == srsp_pkg::SRSP_WR_ACK)
      else $error("Commit without acknowledge");
   a_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R17
      fifoInValid && fifoInReady |=> ptr == PW'($past(ptr) + 1'b1)) else $error("Pointer step wrong");
   a_read_step: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R19
      (state == srsp_pkg::SRSP_RD_DATA) && sclFall && byteIn && !startDet && !stopDet
      |=> ptr == PW'($past(ptr) + 1'b1) && !sdaOe) else $error("Read pointer step wrong");
   a_nack_release: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R11
      seqReadNack |=> !sdaOe[*4]) else $error("Line held after NACK");
   a_sda_low_phase: assert property (@(posedge clk) disable iff (!rst_n || modeS) // R04
      $changed(sdaOe) |-> !$past(sclS)) else $error("Data changed while clock high");

endmodule
`default_nettype wire

// [tb/srsp_master_model.sv]
// Purpose: Behavioural two-wire bus master that drives the serial clock and data lines.
// Assumes: Paced by the falling edge of the system clock; link period is 8 clocks.
// Notes: Data is open drain: the model only pulls low, a pull-up gives the high level.
`timescale 1ns/1ps
`default_nettype none

module srsp_master_model (
   // Pacing clock.
   input wire logic clk,
   // Bus lines.
   output logic scl,
   output logic sdaPull,
   input wire logic sda
);
   // The bus starts idle with both lines high.
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end

   // Waits a number of falling clock edges.
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Start or repeated start: data falls while the clock is high.
   // On a repeated start the clock stays low for a while first, so that a slave acknowledge ends before it rises.
   task automatic start();
      tick(2);
      sdaPull = 1'b0;
      tick(2);
      scl = 1'b1;
      tick(2);
      sdaPull = 1'b1;
      tick(2);
      scl = 1'b0;
   endtask

   // Stop: data rises while the clock is high, then the bus stands idle.
   task automatic stop();
      tick(2);
      sdaPull = 1'b1;
      tick(2);
      scl = 1'b1;
      tick(2);
      sdaPull = 1'b0;
      tick(4);
   endtask

   // One clock pulse carrying one bit; data changes only while the clock is low.
   task automatic bitOut(input logic v, output logic s);
      tick(2);
      sdaPull = !v;
      tick(2);
      scl = 1'b1;
      tick(2);
      s = sda;
      tick(2);
      scl = 1'b0;
   endtask

   // Sends a byte most significant bit first and returns the acknowledge.
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitOut(b[i], s);
      end
      bitOut(1'b1, s);
      ack = !s;
   endtask

   // Receives a byte, then acknowledges it or not.
   task automatic rbyte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 0; i < 8; i++) begin
         bitOut(1'b1, s);
         b = {b[6:0], s};
      end
      bitOut(!more, s);
   endtask

   // Drives both pins as plain levels for run mode.
   task automatic setPins(input logic c, input logic p);
      scl = c;
      sdaPull = p;
   endtask
endmodule

`default_nettype wire

// [tb/tb_serial_register_slave_port.sv]
// Purpose: Self-checking bench of the two-wire register slave port.
// Assumes: 50 MHz clock; inputs change on the falling clock edge.
// Notes: Expected register contents are kept in a local shadow array.
`timescale 1ns/1ps
`default_nettype none
`include "srsp_cfg.svh"

module tb_serial_register_slave_port;
   logic clk, rst_n, modePin, regUpdateHold, scl, mPull, sdaOut, sdaOe;
   logic powerDownReq, outputEnable;
   logic [127:0] ctrlRegs;
   wire sdaLine;
   logic [7:0] expReg [16];
   int nFail, samplesChecked, cycles;

   // Open-drain data wire with pull-up.
   assign sdaLine = ~(mPull | (sdaOe & ~sdaOut));

   srsp_slave dut (.clk(clk), .rst_n(rst_n), .modePin(modePin),
      .powerdown_or_serial_clock_pin(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .regUpdateHold(regUpdateHold), .ctrlRegs(ctrlRegs), .powerDownReq(powerDownReq),
      .outputEnable(outputEnable));
   srsp_master_model m (.clk(clk), .scl(scl), .sdaPull(mPull), .sda(sdaLine));

   // Clock generation.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Prints the verdict and ends the run.
   task automatic finalReport();
      if (nFail == 0 && samplesChecked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // A hang counts as a mismatch.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         nFail++;
         finalReport();
      end
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samplesChecked++;
      if (g !== e) begin
         nFail++;
         $display("wrong value %s expected %0h seen %0h", n, e, g);
      end
   endtask

   task automatic chkRegs();
      for (int i = 0; i < 16; i++) chk("register", expReg[i], ctrlRegs[8*i+:8]);
   endtask

   // Addressed write of n bytes from base upward; returns the acknowledged count.
   task automatic wr(input logic [7:0] p, input int n, input logic [7:0] base, output int acks);
      logic a;
      m.start();
      m.wbyte({`SRSP_OWN_ADDR, 1'b0}, a);
      chk("address ack", 8'h1, {7'h0, a});
      m.wbyte(p, a);
      chk("pointer ack", 8'h1, {7'h0, a});
      acks = 0;
      for (int i = 0; i < n; i++) begin
         m.wbyte(base + i[7:0], a);
         if (a !== 1'b1) break;
         expReg[(p[3:0] + i) % 16] = base + i[7:0];
         acks++;
      end
      m.stop();
      m.tick(6);
   endtask

   // Pointer write, repeated start, then n bytes read back.
   task automatic rd(input logic [7:0] p, input int n);
      logic a;
      logic [7:0] b;
      m.start();
      m.wbyte({`SRSP_OWN_ADDR, 1'b0}, a);
      m.wbyte(p, a);
      m.start();
      m.wbyte({`SRSP_OWN_ADDR, 1'b1}, a);
      chk("read address ack", 8'h1, {7'h0, a});
      for (int i = 0; i < n; i++) begin
         m.rbyte(i != n - 1, b);
         chk("read byte", expReg[(p[3:0] + i) % 16], b);
      end
      chk("released after nack", 8'h0, {7'h0, sdaOe});
      m.stop();
   endtask

   task automatic tReset();
      chkRegs();
      chk("idle data drive", 8'h0, {7'h0, sdaOe});
   endtask

   task automatic tSingle();
      int a;
      wr(8'h03, 1, 8'h5a, a);
      chk("single acks", 8'h1, a[7:0]);
      chkRegs();
      rd(8'h03, 1);
   endtask

   task automatic tSequential();
      int a;
      wr(8'hfe, 4, 8'hc0, a);
      chk("sequential acks", 8'h4, a[7:0]);
      chkRegs();
      rd(8'h0e, 16);
   endtask

   task automatic tRefuse();
      logic [7:0] adr [5] = '{8'ha0, 8'hae, 8'h00, 8'hba, 8'ha1};
      logic a;
      foreach (adr[i]) begin
         m.start();
         m.wbyte(adr[i], a);
         chk("foreign ack", 8'h0, {7'h0, a});
         m.wbyte(8'h02, a);
         m.wbyte(8'hff, a);
         m.stop();
      end
      chkRegs();
   endtask

   task automatic tAbort();
      logic a;
      logic s;
      for (int k = 0; k < 2; k++) begin
         m.start();
         m.wbyte({`SRSP_OWN_ADDR, 1'b0}, a);
         m.wbyte(8'h05 + k[7:0], a);
         for (int i = 0; i < 5; i++) m.bitOut(1'b1, s);
         if (k == 1) m.start();
         m.stop();
         m.tick(6);
      end
      chkRegs();
   endtask

   task automatic tFifoFull();
      int a;
      logic [7:0] old;
      old = expReg[0];
      regUpdateHold = 1'b1;
      wr(8'h00, 9, 8'h30, a);
      chk("buffered acks", 8'h8, a[7:0]);
      chk("held register", old, ctrlRegs[7:0]);
      regUpdateHold = 1'b0;
      m.tick(20);
      chkRegs();
   endtask

   task automatic tRunMode();
      logic a;
      modePin = 1'b1;
      m.tick(8);
      m.setPins(1'b1, 1'b0);
      m.tick(6);
      chk("power down high", 8'h1, {7'h0, powerDownReq});
      chk("enable high", 8'h1, {7'h0, outputEnable});
      m.setPins(1'b0, 1'b1);
      m.tick(6);
      chk("power down low", 8'h0, {7'h0, powerDownReq});
      chk("enable low", 8'h0, {7'h0, outputEnable});
      m.setPins(1'b1, 1'b0);
      m.tick(6);
      m.start();
      m.wbyte({`SRSP_OWN_ADDR, 1'b0}, a);
      chk("run mode ack", 8'h0, {7'h0, a});
      m.stop();
      modePin = 1'b0;
      m.tick(8);
      chkRegs();
   endtask

   // Main sequence.
   initial begin
      rst_n = 1'b0;
      modePin = 1'b0;
      regUpdateHold = 1'b0;
      nFail = 0;
      samplesChecked = 0;
      cycles = 0;
      foreach (expReg[i]) expReg[i] = `SRSP_REG_RESET;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      tReset();
      tSingle();
      tSequential();
      tRefuse();
      tAbort();
      tFifoFull();
      tRunMode();
      finalReport();
   end
endmodule

`default_nettype wire
